// ### hdl/sac_pkg.sv
// constants and types shared by the converter control block
// What this block does and what software must do
// (R1) at conversion end the 8-bit approximation result goes into the result register
// (R2) the result register holds the last result until the next conversion begins
// (R3) reset leaves the result register untouched, its value undefined
// (R4) the result register reads any time, undefined while a conversion runs
// (R5) the mode register resets to 30 hex
// (R6) mode bit 7 picks 62 clocks or the half-length fast period
// (R7) software keeps the conversion time at or above 12.4 us
// (R8) mode bit 6 gates the external trigger, edges ignored while it is 0
// (R9) a selected trigger edge with the gate open sets the active flag and starts
// (R10) mode bits 5 and 4 read 1 and ignore writes
// (R11) channel field: 00xx none, 01xx inputs 0-3, 10xx inputs 4-7, 11xx reserved
// (R12) software changes the channel only while the active flag reads 0
// (R13) writing 1 to start bit 7 begins a conversion on the chosen channel
// (R14) writing 0 to start bit 7 stops any running conversion
// (R15) active flag is 1 during conversion, cleared with the result store, 0 after reset
// (R16) start register bits 6 to 0 read 1 and ignore writes
// (R17) the active flag falling at conversion end sets the done request flag
// (R18) the end interrupt is requested only while flag and enable are both 1
// (R19) software stops a conversion before changing speed or channel
// (R20) after a conversion the converter idles until the next start
// (R21) software reads the result only while the active flag reads 0
// (R22) trigger pin is synchronised, and edges during a conversion are ignored
package sac_pkg;

	// register map, two address bits, every offset mapped
	localparam logic [1:0] MODE_ADDR     = 2'h0;
	localparam logic [1:0] RESULT_ADDR   = 2'h1;
	localparam logic [1:0] START_ADDR    = 2'h2;
	localparam logic [1:0] IRQ_ADDR      = 2'h3;

	// field positions
	localparam int         SPEED_BIT     = 7;
	localparam int         TRIG_EN_BIT   = 6;
	localparam int         START_BIT     = 7;
	localparam int         IRQ_FLAG_BIT  = 7;
	localparam int         IRQ_EN_BIT    = 1;
	localparam int         EDGE_SEL_BIT  = 0;

	// reset and fixed read values
	localparam logic [7:0] MODE_RESET    = 8'h30;
	localparam logic [1:0] MODE_RSVD     = 2'h3;
	localparam logic [6:0] START_RSVD    = 7'h7F;
	localparam logic [4:0] IRQ_RSVD      = 5'h00;

	// conversion period in system clocks; fast figure is 15.5 us at a 2 MHz clock
	localparam logic [5:0] CONV_SLOW_CYC = 6'h3E;
	localparam int         FAST_TIME_NS  = 15500;
	localparam int         REF_CLK_MHZ   = 2;
	localparam logic [5:0] CONV_FAST_CYC = 6'(FAST_TIME_NS * REF_CLK_MHZ / 1000);
	localparam logic [5:0] SLOW_STEP     = 6'(CONV_SLOW_CYC >> 3);
	localparam logic [5:0] FAST_STEP     = 6'(CONV_FAST_CYC >> 3);
	localparam logic [5:0] SLOW_SAMP     = 6'(CONV_SLOW_CYC - (SLOW_STEP << 3));
	localparam logic [5:0] FAST_SAMP     = 6'(CONV_FAST_CYC - (FAST_STEP << 3));

	typedef enum logic [1:0] {
		SAC_IDLE   = 2'b00,
		SAC_SAMPLE = 2'b01,
		SAC_TRIAL  = 2'b10
	} sac_state_t;

endpackage

// ### hdl/sac_sar_if.sv
// link between register control and the approximation engine
`timescale 1ns/100ps
interface sac_sar_if;
	logic       start;
	logic       stop;
	logic       fast;
	logic       comp;
	logic       busy;
	logic       sampling;
	logic       done;
	logic [7:0] result;
	logic [7:0] dac;

	modport ctrl (
		output start, output stop, output fast, output comp,
		input  busy, input sampling, input done, input result, input dac
	);
	modport engine (
		input  start, input stop, input fast, input comp,
		output busy, output sampling, output done, output result, output dac
	);
endinterface

// ### hdl/sac_sar_engine.sv
// successive approximation sequencer: sample phase then eight bit trials
`timescale 1ns/100ps
module sac_sar_engine
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic ce,
	// control and result
	sac_sar_if.engine sar
);
	sac_state_t state_ff;
	logic [5:0] cnt_ff;
	logic [2:0] bit_ff;
	logic [7:0] code_ff;
	logic       fast_ff;
	logic [5:0] step_len;
	logic [7:0] nxt_code;

	// speed is caught at start so a careless mid-run write cannot bend the timing
	assign step_len = fast_ff ? FAST_STEP : SLOW_STEP;
	// comparator high keeps the trial bit: input at or above the ladder tap
	assign nxt_code = sar.comp ? code_ff : (code_ff & ~(8'h01 << bit_ff));

	assign sar.busy     = (state_ff != SAC_IDLE);
	assign sar.sampling = (state_ff == SAC_SAMPLE);
	assign sar.done     = (state_ff == SAC_TRIAL) && (cnt_ff == 6'h00) && (bit_ff == 3'h0);
	assign sar.result   = nxt_code;
	assign sar.dac      = code_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= SAC_IDLE;
			cnt_ff   <= 6'h00;
			bit_ff   <= 3'h0;
			code_ff  <= 8'h00;
			fast_ff  <= 1'b0;
		end else if (ce) begin
			if (sar.stop) begin
				state_ff <= SAC_IDLE;
			end else if (sar.start) begin
				state_ff <= SAC_SAMPLE;
				fast_ff  <= sar.fast;
				cnt_ff   <= (sar.fast ? FAST_SAMP : SLOW_SAMP) - 6'h01; // R6
			end else begin
				case (state_ff)
					SAC_SAMPLE: begin
						if (cnt_ff == 6'h00) begin
							state_ff <= SAC_TRIAL;
							bit_ff   <= 3'h7;
							code_ff  <= 8'h80;
							cnt_ff   <= step_len - 6'h01;
						end else begin
							cnt_ff <= cnt_ff - 6'h01;
						end
					end
					SAC_TRIAL: begin
						if (cnt_ff != 6'h00) begin
							cnt_ff <= cnt_ff - 6'h01;
						end else if (bit_ff == 3'h0) begin
							code_ff  <= nxt_code;
							state_ff <= SAC_IDLE; // R20
						end else begin
							code_ff <= nxt_code | (8'h01 << (bit_ff - 3'h1));
							bit_ff  <= bit_ff - 3'h1;
							cnt_ff  <= step_len - 6'h01;
						end
					end
					default: begin
						state_ff <= SAC_IDLE;
					end
				endcase
			end
		end
	end
endmodule

// ### hdl/sac_adc_ctrl.sv
// register control, trigger handling and result store of the 8-bit converter
`timescale 1ns/100ps
module sac_adc_ctrl
	import sac_pkg::*;
(
	// clock, reset, clock enable
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       ce,
	// register port
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// trigger pin
	input  wire logic       ext_trigger_pin,
	// analog front end
	input  wire logic       comp_in,
	output logic      [7:0] dac_code,
	output logic            sample_hold,
	output logic            chan_en,
	output logic      [2:0] chan_num,
	// conversion end request
	output logic            conv_done_irq_req
);
	sac_sar_if sar ();

	// mode register fields
	logic       conv_speed_sel_ff;
	logic       ext_trigger_en_ff;
	logic [3:0] input_channel_sel_ff;
	// start register and result
	logic       conv_active_flag_ff;
	logic [7:0] conv_result_ff;
	// edge select and request bits
	logic       trigger_edge_sel_ff;
	logic       conv_done_irq_en_ff;
	logic       conv_done_irq_flag_ff;
	// trigger synchroniser and filtered level
	logic       trig_s1_ff;
	logic       trig_s2_ff;
	logic       trig_s3_ff;
	logic       trig_lvl_ff;
	// outputs from flops
	logic [7:0] rdata_ff;
	logic       chan_en_ff;
	logic [2:0] chan_num_ff;
	// helper count of active cycles, read by the checks
	logic [5:0] act_cnt_ff;

	// decoded strobes and events
	logic       wr_mode;
	logic       wr_start;
	logic       wr_irq;
	logic       sw_start;
	logic       sw_stop;
	logic       trig_change;
	logic       trig_edge;
	logic       hw_trig;
	logic       conv_begin;
	logic       conv_end;
	logic [7:0] mode_rd;
	logic [7:0] start_rd;
	logic [7:0] irq_rd;
	logic [7:0] nxt_rdata;

	sac_sar_engine u_engine (
		.clock (clock),
		.rst   (rst),
		.ce    (ce),
		.sar   (sar.engine)
	);

	assign wr_mode  = reg_wr && (reg_addr == MODE_ADDR);
	assign wr_start = reg_wr && (reg_addr == START_ADDR);
	assign wr_irq   = reg_wr && (reg_addr == IRQ_ADDR);
	assign sw_start = wr_start && reg_wdata[START_BIT];  // R13
	assign sw_stop  = wr_start && !reg_wdata[START_BIT]; // R14

	// a change counts only when the second and third stage agree
	assign trig_change = (trig_s2_ff == trig_s3_ff) && (trig_s3_ff != trig_lvl_ff); // R22
	// edge select 1 takes the rising edge, 0 the falling edge
	assign trig_edge   = trig_change && (trig_s3_ff == trigger_edge_sel_ff); // R9
	// edges while converting are dropped rather than restarting the run
	assign hw_trig     = trig_edge && ext_trigger_en_ff && !conv_active_flag_ff; // R8 R22
	// an explicit software stop beats a trigger edge in the same cycle
	assign conv_begin  = sw_start || (hw_trig && !sw_stop); // R9 R13
	// a start register write in the final cycle overrides the completion
	assign conv_end    = sar.done && !wr_start; // R15 R17

	assign sar.start = conv_begin;
	assign sar.stop  = sw_stop; // R14
	assign sar.fast  = conv_speed_sel_ff; // R6 R19
	assign sar.comp  = comp_in;

	// mode register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			conv_speed_sel_ff    <= MODE_RESET[SPEED_BIT]; // R5
			ext_trigger_en_ff    <= MODE_RESET[TRIG_EN_BIT]; // R5
			input_channel_sel_ff <= MODE_RESET[3:0]; // R5
		end else if (ce && wr_mode) begin
			conv_speed_sel_ff    <= reg_wdata[SPEED_BIT]; // R6
			ext_trigger_en_ff    <= reg_wdata[TRIG_EN_BIT]; // R8
			input_channel_sel_ff <= reg_wdata[3:0];
		end
	end

	// channel decode to the multiplexer, 00xx and 11xx select nothing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			chan_en_ff  <= 1'b0;
			chan_num_ff <= 3'h0;
		end else if (ce && wr_mode) begin
			chan_en_ff  <= (reg_wdata[3:2] == 2'b01) || (reg_wdata[3:2] == 2'b10); // R11
			chan_num_ff <= {reg_wdata[3], reg_wdata[1:0]}; // R11
		end
	end

	// active flag
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			conv_active_flag_ff <= 1'b0; // R15
		end else if (ce) begin
			if (conv_begin) begin
				conv_active_flag_ff <= 1'b1; // R9 R13
			end else if (sw_stop || conv_end) begin
				conv_active_flag_ff <= 1'b0; // R14 R15
			end
		end
	end

	// result store has no reset: it powers up and stays undefined until a conversion ends
	always_ff @(posedge clock) begin
		if (ce && conv_end) begin
			conv_result_ff <= sar.result; // R1 R2 R3
		end
	end

	// edge select and request enable
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trigger_edge_sel_ff <= 1'b0;
			conv_done_irq_en_ff <= 1'b0;
		end else if (ce && wr_irq) begin
			trigger_edge_sel_ff <= reg_wdata[EDGE_SEL_BIT];
			conv_done_irq_en_ff <= reg_wdata[IRQ_EN_BIT];
		end
	end

	// request flag: writing 0 clears, a completion in that same cycle still sets it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			conv_done_irq_flag_ff <= 1'b0;
		end else if (ce) begin
			if (conv_end) begin
				conv_done_irq_flag_ff <= 1'b1; // R17
			end else if (wr_irq && !reg_wdata[IRQ_FLAG_BIT]) begin
				conv_done_irq_flag_ff <= 1'b0;
			end
		end
	end

	assign conv_done_irq_req = conv_done_irq_flag_ff && conv_done_irq_en_ff; // R18

	// trigger pin synchroniser, first stage feeds only the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trig_s1_ff <= 1'b0;
			trig_s2_ff <= 1'b0;
			trig_s3_ff <= 1'b0;
		end else if (ce) begin
			trig_s1_ff <= ext_trigger_pin; // R22
			trig_s2_ff <= trig_s1_ff;
			trig_s3_ff <= trig_s2_ff;
		end
	end

	// filtered level; a pin held low at reset release gives no edge, one held high gives a rising edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trig_lvl_ff <= 1'b0;
		end else if (ce && trig_change) begin
			trig_lvl_ff <= trig_s3_ff;
		end
	end

	// read values, fixed bits one in mode and start registers, zero in the request register
	assign mode_rd  = {conv_speed_sel_ff, ext_trigger_en_ff, MODE_RSVD, input_channel_sel_ff}; // R10
	assign start_rd = {conv_active_flag_ff, START_RSVD}; // R16
	assign irq_rd   = {conv_done_irq_flag_ff, IRQ_RSVD, conv_done_irq_en_ff, trigger_edge_sel_ff};

	always_comb begin
		case (reg_addr)
			MODE_ADDR:   nxt_rdata = mode_rd;
			// no read guard: during a run the old result comes back
			RESULT_ADDR: nxt_rdata = conv_result_ff; // R4
			START_ADDR:  nxt_rdata = start_rd;
			IRQ_ADDR:    nxt_rdata = irq_rd;
			default:     nxt_rdata = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else if (ce) begin
			rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
		end
	end

	// cycles spent active since the start, for the period check
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			act_cnt_ff <= 6'h00;
		end else if (ce) begin
			if (conv_begin) begin
				act_cnt_ff <= 6'h01;
			end else if (conv_active_flag_ff) begin
				act_cnt_ff <= act_cnt_ff + 6'h01;
			end else begin
				act_cnt_ff <= 6'h00;
			end
		end
	end

	assign reg_rdata   = rdata_ff;
	assign dac_code    = sar.dac;
	assign sample_hold = sar.sampling;
	assign chan_en     = chan_en_ff;
	assign chan_num    = chan_num_ff;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	sequence seq_start_read;
		ce && reg_rd && (reg_addr == START_ADDR);
	endsequence

	sequence seq_mode_read;
		ce && reg_rd && (reg_addr == MODE_ADDR);
	endsequence

	sequence seq_finish;
		ce && conv_end;
	endsequence

	sequence seq_trig_open;
		ce && trig_edge && ext_trigger_en_ff && !conv_active_flag_ff && !wr_start;
	endsequence

	result_store_a: assert property (seq_finish |=> conv_result_ff == $past(sar.result)) // R1
		else $error("result not stored at conversion end");

	// case equality: the store powers up undefined and must still count as held
	result_hold_a: assert property (ce && !conv_end |=> conv_result_ff === $past(conv_result_ff)) // R2
		else $error("result changed without a completion");

	conv_period_a: assert property (seq_finish |-> // R6
		act_cnt_ff == (conv_speed_sel_ff ? CONV_FAST_CYC : CONV_SLOW_CYC))
		else $error("conversion length differs from selected period");

	trig_gate_a: assert property (ce && trig_edge && !ext_trigger_en_ff && !conv_active_flag_ff // R8
		&& !wr_start |=> !conv_active_flag_ff)
		else $error("trigger edge started a conversion while gated");

	trig_start_a: assert property (seq_trig_open |=> conv_active_flag_ff ##0 sar.sampling) // R9
		else $error("enabled trigger edge did not start a conversion");

	mode_fixed_a: assert property (seq_mode_read |=> reg_rdata[5:4] == MODE_RSVD) // R10
		else $error("mode reserved bits not read as one");

	chan_none_a: assert property (ce && wr_mode && reg_wdata[3:2] == 2'b00 |=> !chan_en) // R11
		else $error("channel enabled for a no-channel code");

	sw_start_a: assert property (ce && sw_start |=> conv_active_flag_ff && sar.sampling) // R13
		else $error("software start did not begin a conversion");

	sw_stop_a: assert property (ce && sw_stop |=> !conv_active_flag_ff && !sar.busy) // R14
		else $error("software stop left the conversion running");

	done_clear_a: assert property (seq_finish |=> !conv_active_flag_ff ##0 !sar.busy) // R15 R20
		else $error("active flag still set after completion");

	start_fixed_a: assert property (seq_start_read |=> reg_rdata[6:0] == START_RSVD // R16
		&& reg_rdata[7] == $past(conv_active_flag_ff))
		else $error("start register read value wrong");

	irq_set_a: assert property (seq_finish |=> conv_done_irq_flag_ff) // R17
		else $error("done flag not set at conversion end");

	irq_gate_a: assert property (ce && conv_end && conv_done_irq_en_ff && !wr_irq // R18
		|=> conv_done_irq_req)
		else $error("enabled completion raised no request");

	trig_busy_a: assert property (ce && conv_active_flag_ff && !wr_start // R22
		&& !conv_end |=> conv_active_flag_ff && act_cnt_ff == $past(act_cnt_ff) + 6'h01)
		else $error("running conversion disturbed by trigger");

endmodule

// ### sim/sac_afe_model.sv
// analog front end model: channel mux, sample-and-hold and comparator
`timescale 1ns/100ps
module sac_afe_model (
	// clock
	input  wire logic        clock,
	// levels of the eight inputs, input 0 in the low byte
	input  wire logic [63:0] levels,
	// mux, hold and ladder
	input  wire logic        chan_en,
	input  wire logic [2:0]  chan_num,
	input  wire logic        sample_hold,
	input  wire logic [7:0]  dac_code,
	output logic             comp_in
);
	logic [7:0] held_ff = 8'h00;

	// a closed mux leaves the hold node at ground, so no channel converts to zero
	always_ff @(posedge clock) begin
		if (sample_hold) begin
			held_ff <= chan_en ? levels[chan_num*8 +: 8] : 8'h00;
		end
	end

	assign comp_in = (held_ff >= dac_code);
endmodule

// ### sim/testbench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module testbench;
	import sac_pkg::*;
	localparam logic [63:0] LEVELS = 64'hF0D1B29374553617;
	logic       clock;
	logic       rst;
	logic       ce;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       ext_trigger_pin;
	logic       comp_in;
	logic [7:0] dac_code;
	logic       sample_hold;
	logic       chan_en;
	logic [2:0] chan_num;
	logic       conv_done_irq_req;
	int         num_errors;
	int         n_compared;
	logic [7:0] rv;
	logic [7:0] prev;

	sac_adc_ctrl u_dut (.clock(clock), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ext_trigger_pin(ext_trigger_pin), .comp_in(comp_in), .dac_code(dac_code),
		.sample_hold(sample_hold), .chan_en(chan_en), .chan_num(chan_num),
		.conv_done_irq_req(conv_done_irq_req));
	sac_afe_model u_afe (.clock(clock), .levels(LEVELS), .chan_en(chan_en),
		.chan_num(chan_num), .sample_hold(sample_hold), .dac_code(dac_code),
		.comp_in(comp_in));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe, so it is taken there
	task automatic rchk(input string what, input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
		check(what, exp, rv);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic pin(input logic v);
		@(posedge clock);
		ext_trigger_pin <= v;
	endtask

	// one software-started conversion, completion edge checked to the cycle
	task automatic convert(input logic [3:0] ch, input logic fast, input logic [7:0] exp);
		int p;
		p = fast ? 31 : 62;
		wr(IRQ_ADDR, 8'h02);
		wr(MODE_ADDR, {fast, 3'b011, ch});
		wr(START_ADDR, 8'h80);
		cyc(p - 1);
		check("req early", 8'h00, 8'(conv_done_irq_req));
		cyc(1);
		check("req at end", 8'h01, 8'(conv_done_irq_req));
		rchk("active end", START_ADDR, 8'h7F);
		rchk("result", RESULT_ADDR, exp);
	endtask

	initial begin
		num_errors = 0;
		n_compared = 0;
		rst = 1'b1;
		ce = 1'b1;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ext_trigger_pin = 1'b0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rchk("mode rst", MODE_ADDR, 8'h30);
		rchk("start rst", START_ADDR, 8'h7F);
		check("req rst", 8'h00, 8'(conv_done_irq_req));
		wr(MODE_ADDR, 8'h05);
		rchk("mode fixed", MODE_ADDR, 8'h35);
		wr(START_ADDR, 8'h00);
		rchk("start fixed", START_ADDR, 8'h7F);
		for (int c = 0; c < 16; c++) begin
			wr(MODE_ADDR, 8'(c));
			cyc(1);
			check("chan en", 8'(c[3] ^ c[2]), 8'(chan_en));
			if (c[3] ^ c[2]) begin
				check("chan num", 8'({c[3], c[1:0]}), 8'(chan_num));
			end
		end
		$display("test registers done");
		// odd inputs use the fast period, so both speeds are timed
		for (int i = 0; i < 8; i++) begin
			convert(4'(i + 4), i[0], LEVELS[i*8 +: 8]);
		end
		convert(4'h1, 1'b0, 8'h00);
		$display("test conversions done");
		rchk("result a", RESULT_ADDR, 8'h00);
		prev = rv;
		cyc(100);
		rchk("idle", START_ADDR, 8'h7F);
		rchk("held", RESULT_ADDR, prev);
		wr(IRQ_ADDR, 8'h80);
		cyc(1);
		check("req masked", 8'h00, 8'(conv_done_irq_req));
		rchk("flag kept", IRQ_ADDR, 8'h80);
		wr(IRQ_ADDR, 8'h82);
		cyc(1);
		check("req unmasked", 8'h01, 8'(conv_done_irq_req));
		wr(IRQ_ADDR, 8'h02);
		wr(MODE_ADDR, 8'h35);
		wr(START_ADDR, 8'h80);
		cyc(20);
		wr(START_ADDR, 8'h00);
		cyc(80);
		rchk("stopped", START_ADDR, 8'h7F);
		check("req stopped", 8'h00, 8'(conv_done_irq_req));
		// a low clock enable freezes the run, so completion slips by the same 10 cycles
		wr(IRQ_ADDR, 8'h02);
		wr(START_ADDR, 8'h80);
		cyc(20);
		@(posedge clock);
		ce <= 1'b0;
		repeat (10) @(posedge clock);
		ce <= 1'b1;
		cyc(40);
		check("req frozen", 8'h00, 8'(conv_done_irq_req));
		cyc(1);
		check("req thawed", 8'h01, 8'(conv_done_irq_req));
		rchk("frozen result", RESULT_ADDR, LEVELS[15:8]);
		$display("test hold and stop done");
		// rising edge selected, so only the closed gate can hold the next edge back
		wr(IRQ_ADDR, 8'h03);
		pin(1'b1);
		cyc(10);
		rchk("gated", START_ADDR, 8'h7F);
		pin(1'b0);
		cyc(10);
		wr(IRQ_ADDR, 8'h03);
		wr(MODE_ADDR, 8'h76);
		pin(1'b1);
		cyc(10);
		rchk("rise start", START_ADDR, 8'hFF);
		pin(1'b0);
		cyc(8);
		// a second rising edge mid-conversion must not restart it
		pin(1'b1);
		cyc(50);
		rchk("no restart", START_ADDR, 8'h7F);
		rchk("trig result", RESULT_ADDR, LEVELS[23:16]);
		wr(IRQ_ADDR, 8'h02);
		pin(1'b0);
		cyc(10);
		rchk("fall start", START_ADDR, 8'hFF);
		cyc(70);
		rchk("fall end", START_ADDR, 8'h7F);
		$display("test trigger done");
		end_of_test();
	end

	// the tests need about 1100 cycles; 25000 means a hang
	initial begin
		#200000;
		num_errors++;
		$display("mismatch watchdog expected finish seen timeout");
		end_of_test();
	end
endmodule
